// File: design/cdfe_device.sv
`timescale 1ns/100ps
module cdfe_device (
	input  wire logic       core_clk,    // Master clock
	input  wire logic       reset,       // Sync reset, high
	cdfe_link_if.dev        link,        // Control link
	input  wire logic [7:0] rfSample,    // HF ADC word
	input  wire logic       rfOver,      // HF ADC overflow
	input  wire logic       rfUnder,     // HF ADC underflow
	input  wire logic [5:0] servoSample, // Servo ADC word, current slot
	input  wire logic       servoOver,   // Servo overflow
	input  wire logic       servoUnder,  // Servo underflow
	output logic      [7:0] outBus,      // Muxed output, bit0/1 flags
	output logic            frameSync,   // High in HF slot before AC
	output logic      [2:0] slotIndex,   // Current slot number
	output logic      [7:0] probeOutput, // Monitor word
	output logic      [7:0] laserDriveOut, // Laser level
	output logic            rightChannelSilence, // Right mute
	output logic            leftChannelSilence,  // Left mute
	output logic            rightBitOut, // Right stream to filter
	output logic            leftBitOut   // Left stream to filter
);
	typedef enum logic [2:0] {IDLE, ADDR, WAIT, REG, DATA, ACK, RD} st_t;
	typedef struct packed {
		logic [1:0]  sclS, sdaS, pdS;
		logic        sclP, sdaP;
		st_t         st;
		logic [3:0]  bitCnt;
		logic [7:0]  sh;
		logic        rd, regSet, ackLow;
		logic [3:0]  ptr;
		logic [15:0][7:0] regs;
		logic [2:0]  slot;
		logic [7:0]  acDat, bdDat, eDat, fDat;
		logic [7:0]  bus, probe, laser;
		logic        sync, muR, muL, bR, bL, sdaO;
		logic [1:0]  mS, bS;
	} cdfe_dev_t;
	cdfe_dev_t r, next_r;
	logic sclRise, sclFall, startC, stopC;
	logic [7:0] servoWord;
	always_comb begin
		next_r = r;
		next_r.sclS = {r.sclS[0], link.scl};
		next_r.sdaS = {r.sdaS[0], link.sda};
		next_r.pdS  = {r.pdS[0], link.powerDownReset_n};
		next_r.mS   = {r.mS[0], link.rightSilence};
		next_r.bS   = {r.bS[0], link.rightBits};
		next_r.sclP = r.sclS[1];
		next_r.sdaP = r.sdaS[1];
		sclRise = r.sclS[1] & ~r.sclP;
		sclFall = ~r.sclS[1] & r.sclP;
		startC = r.sclS[1] & r.sclP & r.sdaP & ~r.sdaS[1];
		stopC  = r.sclS[1] & r.sclP & ~r.sdaP & r.sdaS[1];
		if (startC) begin
			next_r.st = ADDR;
			next_r.bitCnt = 4'h0;
			next_r.regSet = 1'b0;
		end else if (stopC) begin
			next_r.st = IDLE;
		end else if (sclRise) begin
			unique case (r.st)
				ADDR, REG, DATA: begin
					next_r.sh = {r.sh[6:0], r.sdaS[1]};
					next_r.bitCnt = r.bitCnt + 4'h1;
				end
				default: ;
			endcase
		end else if (sclFall) begin
			unique case (r.st)
				IDLE, WAIT: ;
				ADDR: if (r.bitCnt == 4'h8) begin
					next_r.bitCnt = 4'h0;
					next_r.rd = r.sh[0];
					if (r.sh[7:1] == cdfe_pkg::DEV_ADDR) begin
						next_r.st = ACK;
						next_r.ackLow = 1'b1;
						next_r.regSet = r.sh[0];
					end else next_r.st = WAIT;
				end
				REG, DATA: if (r.bitCnt == 4'h8) begin
					next_r.bitCnt = 4'h0;
					next_r.st = ACK;
					next_r.ackLow = 1'b1;
					if (!r.regSet) begin
						next_r.ptr = r.sh[3:0];
						next_r.regSet = 1'b1;
					end else begin
						unique case (r.ptr)
							cdfe_pkg::ADR_GALL: for (int i = 0; i < 4; i++)
								next_r.regs[i] = r.sh;
							cdfe_pkg::ADR_OALL: for (int i = 4; i < 8; i++)
								next_r.regs[i] = r.sh;
							cdfe_pkg::ADR_OVF, cdfe_pkg::ADR_SPARE: ;
							default: next_r.regs[r.ptr] = r.sh;
						endcase
					end
				end
				ACK: begin
					next_r.ackLow = 1'b0;
					if (r.rd) begin
						next_r.st = RD;
						next_r.sh = r.regs[r.ptr];
						if (r.ptr == cdfe_pkg::ADR_OVF)
							next_r.regs[cdfe_pkg::ADR_OVF] = 8'h00;
					end else next_r.st = r.regSet ? DATA : REG;
				end
				RD: if (r.bitCnt == 4'h7) begin
					next_r.st = WAIT;
					next_r.bitCnt = 4'h0;
				end else begin
					next_r.sh = {r.sh[6:0], 1'b0};
					next_r.bitCnt = r.bitCnt + 4'h1;
				end
			endcase
		end
		next_r.sdaO = ~((next_r.st == ACK && next_r.ackLow) ||
			(next_r.st == RD && !next_r.sh[7]));
		if (rfOver)
			next_r.regs[cdfe_pkg::ADR_OVF][cdfe_pkg::OVF_BIT] = 1'b1;
		if (rfUnder)
			next_r.regs[cdfe_pkg::ADR_OVF][cdfe_pkg::UNF_BIT] = 1'b1;
		next_r.slot = r.slot + 3'h1;
		servoWord = {servoSample, servoUnder, servoOver};
		next_r.bus = next_r.slot[0] ? rfSample : servoWord;
		unique case (next_r.slot)
			3'h0: next_r.acDat = servoWord;
			3'h2: next_r.bdDat = servoWord;
			3'h4: next_r.eDat  = servoWord;
			3'h6: next_r.fDat  = servoWord;
			default: ;
		endcase
		next_r.sync = (next_r.slot == 3'h7);
		unique case (r.regs[cdfe_pkg::ADR_MON][2:0])
			cdfe_pkg::MON_AC: next_r.probe = r.acDat;
			cdfe_pkg::MON_BD: next_r.probe = r.bdDat;
			cdfe_pkg::MON_E:  next_r.probe = r.eDat;
			cdfe_pkg::MON_F:  next_r.probe = r.fDat;
			default:          next_r.probe = rfSample;
		endcase
		next_r.laser = r.regs[cdfe_pkg::ADR_LASER];
		next_r.muR = r.mS[1];
		next_r.muL = link.leftSilence;
		next_r.bR = r.bS[1] & ~r.mS[1];
		next_r.bL = link.leftBits & ~link.leftSilence;
		if (!r.pdS[1]) begin
			next_r.regs = '0;
			next_r.st = IDLE;
			next_r.sdaO = 1'b1;
			next_r.bus = 8'h00;
			next_r.sync = 1'b0;
		end
	end
	always_ff @(posedge core_clk) begin
		if (reset) begin
			r <= '0;
			r.sclS <= 2'b11;
			r.sdaS <= 2'b11;
			r.sclP <= 1'b1;
			r.sdaP <= 1'b1;
			r.sdaO <= 1'b1;
		end else r <= next_r;
	end
	assign link.sdaDevO    = 1'b0;
	assign link.sdaDevOe_n = r.sdaO;
	assign outBus = r.bus;
	assign frameSync = r.sync;
	assign slotIndex = r.slot;
	assign probeOutput = r.probe;
	assign laserDriveOut = r.laser;
	assign rightChannelSilence = r.muR;
	assign leftChannelSilence = r.muL;
	assign rightBitOut = r.bR;
	assign leftBitOut = r.bL;
endmodule : cdfe_device

// File: design/cdfe_pkg.sv
// How it works
// - Sixteen eight-bit registers, four-bit address
// - Fixed address decode per register group
// - Offsets at 4..7 in channel order
// - Addresses 14/15 broadcast to gains/offsets
// - Overflow register ignores writes
// - Monitor select picks HF, AC, BD, E, F
// - Sync high in HF slot before AC
// - Bit 1 carries HF bit1 or underflow
// - Bit 0 carries HF bit0 or overflow
// - Mute inputs active high
// - Power down reset input active low
// - Data line open drain, pulled up
// - Controller makes link clock
// - Controller supplies left/right bitstreams
// - Eight slot frame order, fixed
// - HF over/underflow latched for readback
// - Gain codes 0..47, half-dB steps
package cdfe_pkg;
	localparam logic [6:0] DEV_ADDR   = 7'h2A; // Arbitrary bus address
	localparam logic [3:0] ADR_GAIN0  = 4'h0;
	localparam logic [3:0] ADR_OFS0   = 4'h4;
	localparam logic [3:0] ADR_MON    = 4'h8;
	localparam logic [3:0] ADR_LASER  = 4'h9;
	localparam logic [3:0] ADR_PLL    = 4'hA;
	localparam logic [3:0] ADR_OVF    = 4'hB;
	localparam logic [3:0] ADR_TEST   = 4'hC;
	localparam logic [3:0] ADR_SPARE  = 4'hD;
	localparam logic [3:0] ADR_GALL   = 4'hE;
	localparam logic [3:0] ADR_OALL   = 4'hF;
	localparam logic [7:0] GAIN_MAX   = 8'h2F;
	localparam logic [2:0] MON_HF     = 3'h0;
	localparam logic [2:0] MON_AC     = 3'h1;
	localparam logic [2:0] MON_BD     = 3'h2;
	localparam logic [2:0] MON_E      = 3'h3;
	localparam logic [2:0] MON_F      = 3'h4;
	localparam int         OVF_BIT    = 0;
	localparam int         UNF_BIT    = 1;
	localparam int         SCL_HALF   = 4; // Core cycles per link quarter period
	// Wishbone registers of the controller
	localparam logic [3:0] WB_CTRL    = 4'h0; // [0]go [1]read [2]pdn [3]mL [4]mR
	localparam logic [3:0] WB_ADDR    = 4'h4; // [3:0] target register
	localparam logic [3:0] WB_WDATA   = 4'h8;
	localparam logic [3:0] WB_STATUS  = 4'hC; // [0]busy [1]nack [15:8]rdata
endpackage : cdfe_pkg

// File: design/cdfe_link_if.sv
`timescale 1ns/100ps
interface cdfe_link_if;
	logic       scl;       // Link clock from controller
	logic       sdaDevO;   // Device data drive value
	logic       sdaDevOe_n; // Device enable, low drives
	logic       sdaCtlO;   // Controller data drive value
	logic       sdaCtlOe_n; // Controller enable, low drives
	logic       sda;       // Resolved data line
	logic       powerDownReset_n;
	logic       rightSilence;
	logic       leftSilence;
	logic       leftBits;
	logic       rightBits;
	assign sda = ~((~sdaDevOe_n & ~sdaDevO) | (~sdaCtlOe_n & ~sdaCtlO));
	modport dev (input scl, sda, powerDownReset_n, rightSilence, leftSilence,
		leftBits, rightBits, output sdaDevO, sdaDevOe_n);
	modport ctl (input sda, output scl, sdaCtlO, sdaCtlOe_n,
		powerDownReset_n, rightSilence, leftSilence, leftBits, rightBits);
endinterface : cdfe_link_if

// File: design/cdfe_controller.sv
`timescale 1ns/100ps
module cdfe_controller (
	input  wire logic        core_clk,  // Core clock
	input  wire logic        reset,     // Sync reset, high
	input  wire logic        wb_cyc_i,  // Wishbone cycle
	input  wire logic        wb_stb_i,  // Wishbone strobe
	input  wire logic        wb_we_i,   // Write enable
	input  wire logic [3:0]  wb_adr_i,  // Byte address
	input  wire logic [3:0]  wb_sel_i,  // Byte lanes
	input  wire logic [31:0] wb_dat_i,  // Write data
	output logic      [31:0] wb_dat_o,  // Read data
	output logic             wb_ack_o,  // Acknowledge
	input  wire logic        leftBitsIn,  // Left stream source
	input  wire logic        rightBitsIn, // Right stream source
	cdfe_link_if.ctl         link       // Control link
);
	typedef enum logic [1:0] {C_IDLE, C_BIT, C_STOP} cst_t;
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
		logic [4:0]  ctrl;
		logic [3:0]  addr;
		logic [7:0]  wdata, rdata;
		logic        nack;
		cst_t        st;
		logic [1:0]  ph;
		logic [2:0]  div;
		logic [5:0]  bitNo;
		logic [35:0] sh;
		logic        scl, sdaO, sdaIn;
		logic        lB, rB;
	} cdfe_ctl_t;
	cdfe_ctl_t r, next_r;
	logic [5:0] lastBit, nextBit;
	logic ackSlot, rdSlot;
	always_comb begin
		next_r = r;
		next_r.ack = 1'b0;
		next_r.sdaIn = link.sda;
		next_r.lB = leftBitsIn;
		next_r.rB = rightBitsIn;
		// Slot 18 of a read is the repeated start, 36 the master nack
		lastBit = r.ctrl[1] ? 6'd36 : 6'd26;
		nextBit = r.bitNo + 6'd1;
		ackSlot = (r.bitNo == 6'd8) || (r.bitNo == 6'd17) ||
			(r.bitNo == 6'd26 && !r.ctrl[1]) ||
			(r.bitNo == 6'd27 && r.ctrl[1]);
		rdSlot = r.ctrl[1] && r.bitNo >= 6'd28 && r.bitNo <= 6'd35;
		if (wb_cyc_i && wb_stb_i && !r.ack) begin
			next_r.ack = 1'b1;
			next_r.dat = 32'h0000_0000;
			unique case (wb_adr_i)
				cdfe_pkg::WB_CTRL: next_r.dat = {27'h0, r.ctrl};
				cdfe_pkg::WB_ADDR: next_r.dat = {28'h0, r.addr};
				cdfe_pkg::WB_WDATA: next_r.dat = {24'h0, r.wdata};
				cdfe_pkg::WB_STATUS: next_r.dat =
					{16'h0, r.rdata, 6'h0, r.nack, r.st != C_IDLE};
				default: ;
			endcase
			if (wb_we_i && wb_sel_i[0]) begin
				unique case (wb_adr_i)
					cdfe_pkg::WB_CTRL: begin
						next_r.ctrl[4:1] = wb_dat_i[4:1];
						if (wb_dat_i[0] && r.st == C_IDLE) begin
							next_r.ctrl[0] = 1'b1;
							next_r.nack = 1'b0;
							next_r.st = C_BIT;
							next_r.bitNo = 6'h3F;
							next_r.div = 3'h0;
							next_r.ph = 2'h1;
							// start, address, pointer, data or restart
							next_r.sh = wb_dat_i[1]
								? {cdfe_pkg::DEV_ADDR, 1'b0, 1'b1, 4'h0,
								r.addr, 1'b1, 1'b1, cdfe_pkg::DEV_ADDR,
								1'b1, 1'b1, 8'hFF}
								: {cdfe_pkg::DEV_ADDR, 1'b0, 1'b1, 4'h0,
								r.addr, 1'b1, r.wdata, 1'b1, 9'h1FF};
							next_r.sdaO = 1'b0;
						end
					end
					cdfe_pkg::WB_ADDR: next_r.addr = wb_dat_i[3:0];
					cdfe_pkg::WB_WDATA: next_r.wdata = wb_dat_i[7:0];
					default: ;
				endcase
			end
		end
		if (r.st != C_IDLE) begin
			next_r.div = r.div + 3'h1;
			if (r.div == 3'(cdfe_pkg::SCL_HALF - 1)) begin
				next_r.div = 3'h0;
				next_r.ph = r.ph + 2'h1;
				unique case (r.ph)
					2'h0: next_r.scl = 1'b1;
					2'h1: begin
						if (r.st == C_BIT && ackSlot && r.sdaIn)
							next_r.nack = 1'b1;
						if (r.st == C_BIT && rdSlot)
							next_r.rdata = {r.rdata[6:0], r.sdaIn};
						// repeated start: data falls, clock high
						if (r.st == C_BIT && r.ctrl[1] && r.bitNo == 6'd18)
							next_r.sdaO = 1'b0;
						if (r.st == C_STOP) begin
							next_r.sdaO = 1'b1;
							next_r.st = C_IDLE;
							next_r.ctrl[0] = 1'b0;
						end
					end
					2'h2: next_r.scl = 1'b0;
					2'h3: if (r.st == C_BIT) begin
						if (r.bitNo == lastBit) begin
							next_r.st = C_STOP;
							next_r.sdaO = 1'b0;
						end else begin
							next_r.bitNo = nextBit;
							next_r.sdaO = (nextBit > 6'd35) ? 1'b1
								: r.sh[6'd35 - nextBit];
						end
					end
				endcase
			end
		end
	end
	always_ff @(posedge core_clk) begin
		if (reset) begin
			r <= '0;
			r.scl <= 1'b1;
			r.sdaO <= 1'b1;
			r.sdaIn <= 1'b1;
		end else r <= next_r;
	end
	assign wb_dat_o = r.dat;
	assign wb_ack_o = r.ack;
	assign link.scl = r.scl;
	assign link.sdaCtlO = 1'b0;
	assign link.sdaCtlOe_n = r.sdaO;
	assign link.powerDownReset_n = ~r.ctrl[2];
	assign link.leftSilence = r.ctrl[3];
	assign link.rightSilence = r.ctrl[4];
	assign link.leftBits = r.lB;
	assign link.rightBits = r.rB;
endmodule : cdfe_controller

// File: dv/cdfe_link_checker.sv
`timescale 1ns/100ps
module cdfe_link_checker (
	input wire logic core_clk,         // Core clock
	input wire logic reset,            // Sync reset, high
	input wire logic scl,              // Link clock
	input wire logic sda,              // Resolved data line
	input wire logic sdaDevO,          // Device drive value
	input wire logic sdaDevOe_n,       // Device enable, low drives
	input wire logic sdaCtlO,          // Controller drive value
	input wire logic sdaCtlOe_n,       // Controller enable, low drives
	input wire logic powerDownReset_n  // Power down, low
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);
	sequence s_start;
		scl && $fell(sda);
	endsequence
	sequence s_stop;
		scl && $rose(sda);
	endsequence
	a_dev_low_only: assert property (!sdaDevOe_n |-> !sdaDevO)
		else $error("device drives data line high");
	a_ctl_low_only: assert property (!sdaCtlOe_n |-> !sdaCtlO)
		else $error("controller drives data line high");
	a_scl_high_hold: assert property ($rose(scl) |=> scl [*3])
		else $error("link clock high phase too short");
	a_scl_low_hold: assert property ($fell(scl) |=> !scl [*3])
		else $error("link clock low phase too short");
	a_dev_change_low: assert property ($changed(sdaDevOe_n) |-> !scl)
		else $error("device changed data while clock high");
	a_start_frame: assert property (s_start |-> ##[1:8] !scl)
		else $error("no clock after start condition");
	a_stop_idle: assert property (s_stop |=> sda [*3])
		else $error("data line not idle after stop");
	a_dev_release: assert property ($fell(sdaDevOe_n) |->
		##[1:160] sdaDevOe_n)
		else $error("device holds data line too long");
	a_pdn_quiet: assert property (!powerDownReset_n [*4] |-> sdaDevOe_n)
		else $error("device drives data during power down");
endmodule : cdfe_link_checker

// File: dv/test_cd_front_end_control_regs.sv
`timescale 1ns/100ps
module test_cd_front_end_control_regs;
	logic        core_clk = 1'b0;
	logic        reset = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [3:0]  adr = 4'h0, sel = 4'h0;
	logic [31:0] datW = 32'h0, datR;
	logic        ack, sync, silR, silL, bitR, bitL;
	logic [7:0]  rf = 8'h00, outBus, probe, laser;
	logic [7:0]  mdl [0:15];
	logic [5:0]  servo = 6'h00;
	logic        rfOv = 1'b0, rfUn = 1'b0, svOv = 1'b0, svUn = 1'b0;
	logic [2:0]  slot, ctrlBits = 3'h0;
	logic [3:0]  cnt = 4'h0;
	logic [31:0] seed = 32'h9007;
	int          failures = 0, cmp_count = 0;

	cdfe_link_if link ();
	cdfe_device cdfe_device_inst (.core_clk(core_clk), .reset(reset),
		.link(link), .rfSample(rf), .rfOver(rfOv), .rfUnder(rfUn),
		.servoSample(servo), .servoOver(svOv), .servoUnder(svUn),
		.outBus(outBus), .frameSync(sync), .slotIndex(slot),
		.probeOutput(probe), .laserDriveOut(laser),
		.rightChannelSilence(silR), .leftChannelSilence(silL),
		.rightBitOut(bitR), .leftBitOut(bitL));
	cdfe_controller cdfe_controller_inst (.core_clk(core_clk),
		.reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR),
		.wb_ack_o(ack), .leftBitsIn(cnt[0] ^ cnt[2]), .rightBitsIn(cnt[1]),
		.link(link));
	cdfe_link_checker cdfe_link_checker_inst (.core_clk(core_clk),
		.reset(reset), .scl(link.scl), .sda(link.sda),
		.sdaDevO(link.sdaDevO), .sdaDevOe_n(link.sdaDevOe_n),
		.sdaCtlO(link.sdaCtlO), .sdaCtlOe_n(link.sdaCtlOe_n),
		.powerDownReset_n(link.powerDownReset_n));

	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cnt <= cnt + 4'h1;
	end

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// Gain codes stay within the 48 valid steps
	function logic [7:0] val(input int r);
		logic [31:0] v;
		v = rnd();
		return (r < 4 || r == 14) ? 8'(v % 48) : v[7:0];
	endfunction : val

	function void mdlWrite(input logic [3:0] r, input logic [7:0] d);
		if (r == cdfe_pkg::ADR_GALL) begin
			for (int i = 0; i < 4; i++) mdl[i] = d;
		end else if (r == cdfe_pkg::ADR_OALL) begin
			for (int i = 4; i < 8; i++) mdl[i] = d;
		end else if (r != cdfe_pkg::ADR_OVF && r != cdfe_pkg::ADR_SPARE) begin
			mdl[r] = d;
		end
	endfunction : mdlWrite

	function logic [7:0] expOut(input logic [2:0] s, input logic [7:0] h,
		input logic [5:0] v, input logic u, input logic o);
		return s[0] ? h : {v, u, o};
	endfunction : expOut

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task conclude();
		if (failures == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : conclude

	task wb(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge core_clk);
		{cyc, stb, we, adr, sel, datW} <= {2'b11, w, a, 4'h1, d};
		do begin
			@(posedge core_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) failures++;
		q = datR;
		{cyc, stb, we} <= 3'b000;
	endtask : wb

	task linkOp(input logic rd, input logic [3:0] r, input logic [7:0] d,
		output logic [7:0] q);
		logic [31:0] t;
		int n;
		n = 0;
		wb(1'b1, cdfe_pkg::WB_ADDR, {28'h0, r}, t);
		wb(1'b1, cdfe_pkg::WB_WDATA, {24'h0, d}, t);
		wb(1'b1, cdfe_pkg::WB_CTRL, {27'h0, ctrlBits, rd, 1'b1}, t);
		do begin
			wb(1'b0, cdfe_pkg::WB_STATUS, 32'h0, t);
			n++;
		end while (t[0] !== 1'b0 && n < 300);
		if (n >= 300) failures++;
		q = t[15:8];
		chk("link nack", 32'h0, {31'h0, t[1]});
	endtask : linkOp

	task wr(input logic [3:0] r, input logic [7:0] d);
		logic [7:0] q;
		linkOp(1'b0, r, d, q);
		mdlWrite(r, d);
	endtask : wr

	task checkAll();
		logic [7:0] q;
		for (int r = 0; r < 13; r++) begin
			linkOp(1'b1, r[3:0], 8'h00, q);
			chk($sformatf("reg %0d", r), {24'h0, mdl[r]}, {24'h0, q});
		end
		chk("laser", {24'h0, mdl[9]}, {24'h0, laser});
	endtask : checkAll

	initial begin
		#(80000 * 10);
		failures++;
		conclude();
	end

	initial begin
		logic [7:0]  q;
		logic [2:0]  prev;
		logic [31:0] t;
		for (int i = 0; i < 16; i++) mdl[i] = 8'h00;
		repeat (4) @(posedge core_clk);
		reset <= 1'b0;
		checkAll();
		wb(1'b0, 4'h2, 32'h0, t);
		chk("unmapped", 32'h0, t);
		for (int i = 0; i < 14; i++) wr(i[3:0], val(i));
		checkAll();
		wr(cdfe_pkg::ADR_GALL, val(14));
		wr(cdfe_pkg::ADR_OALL, val(15));
		checkAll();
		rf <= 8'(rnd());
		for (int c = 0; c < 8; c++) begin
			wr(cdfe_pkg::ADR_MON, 8'(c));
			if (c == 0 || c > 4) chk("probe", {24'h0, rf}, {24'h0, probe});
			else chk("probe servo", 32'h0, {24'h0, probe});
		end
		for (int f = 0; f < 4; f++) begin
			{svUn, svOv} <= 2'(f);
			servo <= 6'(rnd());
			rf <= 8'(rnd());
			repeat (8) @(posedge core_clk);
			for (int k = 0; k < 9; k++) begin
				@(posedge core_clk);
				#2;
				chk("outBus", {24'h0, expOut(slot, rf, servo, svUn, svOv)},
					{24'h0, outBus});
				chk("sync", {31'h0, slot == 3'h7}, {31'h0, sync});
				if (k > 0) chk("slot", {29'h0, prev + 3'h1}, {29'h0, slot});
				prev = slot;
			end
		end
		rfOv <= 1'b1;
		@(posedge core_clk);
		rfOv <= 1'b0;
		rfUn <= 1'b1;
		@(posedge core_clk);
		rfUn <= 1'b0;
		wr(cdfe_pkg::ADR_OVF, 8'h00);
		linkOp(1'b1, cdfe_pkg::ADR_OVF, 8'h00, q);
		chk("flags", (32'h1 << cdfe_pkg::OVF_BIT) | (32'h1 << cdfe_pkg::UNF_BIT),
			{24'h0, q});
		linkOp(1'b1, cdfe_pkg::ADR_OVF, 8'h00, q);
		chk("flags cleared", 32'h0, {24'h0, q});
		for (int m = 0; m < 4; m++) begin
			ctrlBits = {m[1], m[0], 1'b0};
			linkOp(1'b1, cdfe_pkg::ADR_LASER, 8'h00, q);
			chk("left_channel_silence", {31'h0, m[0]}, {31'h0, silL});
			chk("right_channel_silence", {31'h0, m[1]}, {31'h0, silR});
			chk("wire left_channel_silence", {31'h0, m[0]}, {31'h0, link.leftSilence});
			if (m[0]) chk("bitL", 32'h0, {31'h0, bitL});
			if (m[1]) chk("bitR", 32'h0, {31'h0, bitR});
		end
		rfOv <= 1'b1;
		@(posedge core_clk);
		rfOv <= 1'b0;
		ctrlBits = 3'b001;
		wb(1'b1, cdfe_pkg::WB_CTRL, {27'h0, ctrlBits, 2'b00}, t);
		repeat (8) @(posedge core_clk);
		chk("pdn", 32'h0, {31'h0, link.powerDownReset_n});
		ctrlBits = 3'b000;
		wb(1'b1, cdfe_pkg::WB_CTRL, {27'h0, ctrlBits, 2'b00}, t);
		for (int i = 0; i < 16; i++) mdl[i] = 8'h00;
		checkAll();
		conclude();
	end
endmodule : test_cd_front_end_control_regs
